// file: design/ipr_top.sv
// Four-level prioritizer with AXI4-Lite registers and CPU vector port
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ipr_map.svh"

// Overview of operation
// R1: Seven request sources, each placed at one of four levels.
// R2: Level is high bit and low bit together; 11 highest, 00 lowest.
// R3: Grant an enabled request when no equal or higher level runs.
// R4: Hold a request pending while an equal or higher level runs.
// R5: Higher level preempts lower; lower resumes after higher returns.
// R6: Ties go by poll order ext0,t0,ext1,t1,array,serial,t2 with vectors.
// R7: Clear edge external and timer 0/1 flags on vectoring, no others.
// R8: Per-source enable bit one admits the request, zero masks it.
// R9: Enable bit 7 gates every source; bits 6..0 per source.
// R10: Both priority registers share that bit layout; bit 7 unused.
module ipr_top (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [6:0]  src_req,
    input  wire logic [1:0]  ext_edge_mode,
    input  wire logic        vector_ack,
    input  wire logic        handler_return,
    output logic             irq_req,
    output logic [7:0]       irq_vector,
    output logic [6:0]       flag_clear,
    output logic             irq
);
    // Register select codes
    localparam logic [2:0] SEL_NONE  = 3'h0;
    localparam logic [2:0] SEL_EN    = 3'h1;
    localparam logic [2:0] SEL_PRL   = 3'h2;
    localparam logic [2:0] SEL_PRH   = 3'h3;
    localparam logic [2:0] SEL_STAT  = 3'h4;
    localparam logic [2:0] SEL_MASK  = 3'h5;
    localparam logic [2:0] SEL_STATE = 3'h6;

    logic [7:0]          interrupt_enable;
    logic [7:0]          priority_lower_bits;
    logic [7:0]          priority_upper_bits;
    logic [2:0]          ev_status;
    logic [2:0]          ev_mask;
    logic [2:0]          ev_now;
    logic [6:0]          active;
    logic                grant_ok;
    logic                take;
    logic                wr_go;
    logic                rd_go;
    logic [2:0]          wr_sel;
    logic [2:0]          rd_sel;
    logic [7:0]          rd_byte;
    ipr_pkg::ipr_grant_t win;
    ipr_pkg::ipr_grant_t offer;
    ipr_pkg::ipr_ins_t   ins;

    // Word address to register select
    function automatic logic [2:0] reg_sel(input logic [11:0] a);
        case (a[11:2])
            `IPR_EN_IDX:    reg_sel = SEL_EN;
            `IPR_PRL_IDX:   reg_sel = SEL_PRL;
            `IPR_PRH_IDX:   reg_sel = SEL_PRH;
            `IPR_STAT_IDX:  reg_sel = SEL_STAT;
            `IPR_MASK_IDX:  reg_sel = SEL_MASK;
            `IPR_STATE_IDX: reg_sel = SEL_STATE;
            default:        reg_sel = SEL_NONE;
        endcase
    endfunction

    // Vector address of a source bit
    function automatic logic [7:0] vec_of(input logic [2:0] b);
        case (b)
            `IPR_SRC_EXT0: vec_of = `IPR_VEC_EXT0;
            `IPR_SRC_T0:   vec_of = `IPR_VEC_T0;
            `IPR_SRC_EXT1: vec_of = `IPR_VEC_EXT1;
            `IPR_SRC_T1:   vec_of = `IPR_VEC_T1;
            `IPR_SRC_SER:  vec_of = `IPR_VEC_SER;
            `IPR_SRC_T2:   vec_of = `IPR_VEC_T2;
            default:       vec_of = `IPR_VEC_CA;
        endcase
    endfunction

    // Flags the hardware clears when a source is vectored
    function automatic logic [6:0] hw_clear(input logic [2:0] b,
                                            input logic [1:0] edge_m);
        hw_clear = 7'h00;
        case (b)
            `IPR_SRC_EXT0: hw_clear[b] = edge_m[0];
            `IPR_SRC_EXT1: hw_clear[b] = edge_m[1];
            `IPR_SRC_T0:   hw_clear[b] = 1'b1;
            `IPR_SRC_T1:   hw_clear[b] = 1'b1;
            default:       hw_clear    = 7'h00;
        endcase
    endfunction

    // Enable gating: global gate and per-source bits
    assign active = src_req & interrupt_enable[6:0] // R8
                  & {7{interrupt_enable[`IPR_GATE_BIT]}}; // R9

    // Winner over seven sources and four levels
    ipr_arbiter u_arb (
        .active  (active),  // R1
        .lo_bits (priority_lower_bits[6:0]), // R10
        .hi_bits (priority_upper_bits[6:0]), // R10
        .win     (win)
    );

    // Nesting record of levels in service
    ipr_in_service u_ins (
        .clk        (clk),
        .resetn     (resetn),
        .push       (take),
        .push_level (offer.level),
        .pop        (handler_return),
        .st         (ins)
    );

    // Grant only above every level already in service
    assign grant_ok = win.valid && (!ins.any || win.level > ins.top); // R3
    assign take     = vector_ack && offer.valid;
    assign irq_req  = offer.valid;

    // Offer register; dropped for the cycle after the CPU takes it
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            offer <= '0;
        else if (take)
            offer <= '0;
        else if (grant_ok)
            offer <= win; // R5
        else
            offer <= '0; // R4
    end

    // Vector of the offered source
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irq_vector <= 8'h00;
        else if (grant_ok && !take)
            irq_vector <= vec_of(win.src); // R6
    end

    // One-cycle clear pulses to the sources after vectoring
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            flag_clear <= 7'h00;
        else if (take)
            flag_clear <= hw_clear(offer.src, ext_edge_mode); // R7
        else
            flag_clear <= 7'h00;
    end

    // Events: vector taken, preemption, request held back
    assign ev_now[`IPR_EV_TAKE]    = take;
    assign ev_now[`IPR_EV_PREEMPT] = take && ins.any;
    assign ev_now[`IPR_EV_HOLD]    = win.valid && !grant_ok;

    // Bus handshakes
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_sel        = reg_sel(s_axi_awaddr);
    assign rd_sel        = reg_sel(s_axi_araddr);

    // Enable, priority and event mask registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            interrupt_enable    <= `IPR_EN_RST;
            priority_lower_bits <= `IPR_PRL_RST;
            priority_upper_bits <= `IPR_PRH_RST;
            ev_mask             <= `IPR_EV_RST;
        end
        else if (wr_go && s_axi_wstrb[0])
        begin
            case (wr_sel)
                SEL_EN:   interrupt_enable <= s_axi_wdata[7:0];
                SEL_PRL:  priority_lower_bits <= {1'b0, s_axi_wdata[6:0]};
                SEL_PRH:  priority_upper_bits <= {1'b0, s_axi_wdata[6:0]};
                SEL_MASK: ev_mask <= s_axi_wdata[2:0];
                default:  ev_mask <= ev_mask;
            endcase
        end
    end

    // Sticky event status; write one clears, a new event wins
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ev_status <= `IPR_EV_RST;
        else if (wr_go && s_axi_wstrb[0] && wr_sel == SEL_STAT)
            ev_status <= (ev_status & ~s_axi_wdata[2:0]) | ev_now;
        else
            ev_status <= ev_status | ev_now;
    end

    // Level interrupt from unmasked status
    assign irq = |(ev_status & ev_mask);

    // Write response
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `IPR_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == SEL_NONE || wr_sel == SEL_STATE)
                          ? `IPR_RESP_SLV : `IPR_RESP_OKAY;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read data selection
    always_comb
    begin
        case (rd_sel)
            SEL_EN:    rd_byte = interrupt_enable;
            SEL_PRL:   rd_byte = priority_lower_bits;
            SEL_PRH:   rd_byte = priority_upper_bits;
            SEL_STAT:  rd_byte = {5'h00, ev_status};
            SEL_MASK:  rd_byte = {5'h00, ev_mask};
            SEL_STATE: rd_byte = {offer.valid, offer.src, ins.mask};
            default:   rd_byte = 8'h00;
        endcase
    end

    // Read response
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `IPR_RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= (rd_sel == SEL_NONE)
                          ? `IPR_RESP_SLV : `IPR_RESP_OKAY;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Vectoring steps for the clear check
    sequence s_take_hw;
        take && hw_clear(offer.src, ext_edge_mode) != 7'h00;
    endsequence

    sequence s_take_sw;
        take && hw_clear(offer.src, ext_edge_mode) == 7'h00;
    endsequence

    level_from_bits_a: assert property (@(posedge clk) disable iff (!resetn)
        win.valid |-> win.level == {priority_upper_bits[win.src],
                                    priority_lower_bits[win.src]}) // R2
        else $error("winner level not from its priority bits");

    free_grant_a: assert property (@(posedge clk) disable iff (!resetn)
        (win.valid && !ins.any && !take) |=> irq_req) // R3
        else $error("idle request not offered");

    hold_pending_a: assert property (@(posedge clk) disable iff (!resetn)
        (ins.any && !(win.valid && win.level > ins.top)) |=> !irq_req) // R4
        else $error("request offered over equal or higher level");

    preempt_up_a: assert property (@(posedge clk) disable iff (!resetn)
        (irq_req && ins.any) |-> offer.level > ins.top) // R5
        else $error("preemption offered at non-higher level");

    poll_vector_a: assert property (@(posedge clk) disable iff (!resetn)
        irq_req |-> irq_vector == vec_of(offer.src)
                 && $past(active[win.src])) // R6
        else $error("vector does not match offered source");

    hw_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        s_take_hw |=> $onehot(flag_clear) ##1 flag_clear == 7'h00) // R7
        else $error("hardware clear pulse wrong");

    sw_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        s_take_sw |=> flag_clear == 7'h00) // R7
        else $error("software-cleared flag was cleared");

    enable_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        irq_req |-> $past(interrupt_enable[win.src])) // R8
        else $error("disabled source offered");

    global_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        !interrupt_enable[`IPR_GATE_BIT] [*2] |-> !irq_req) // R9
        else $error("request offered with global gate off");

    take_irq_a: assert property (@(posedge clk) disable iff (!resetn)
        (take && ev_mask[`IPR_EV_TAKE]) |=> irq [*2])
        else $error("taken event did not raise interrupt");

    // Vector hand-off, clear pulses, registers and status side
    offer_drop_a: assert property (@(posedge clk) disable iff (!resetn)
        take |=> !irq_req && ins.mask[$past(offer.level)]) // R4
        else $error("taken vector still offered or level not recorded");

    clear_cause_a: assert property (@(posedge clk) disable iff (!resetn)
        flag_clear != 7'h00 |-> $past(take)) // R7
        else $error("flag clear pulse without a taken vector");

    prio_top_bit_a: assert property (@(posedge clk) disable iff (!resetn)
        !priority_lower_bits[7] && !priority_upper_bits[7]) // R10
        else $error("unused priority bit set");

    set_wins_a: assert property (@(posedge clk) disable iff (!resetn)
        |ev_now |=> (ev_status & $past(ev_now)) == $past(ev_now))
        else $error("status event lost");

    rdata_upper_a: assert property (@(posedge clk) disable iff (!resetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data above byte 0 not zero");
endmodule

// file: design/ipr_map.svh
// Register offsets, field positions and codes of the prioritizer
`ifndef IPR_MAP_SVH
`define IPR_MAP_SVH

// Register indices; byte address is four times the index
`define IPR_EN_IDX     10'h0A8
`define IPR_PRH_IDX    10'h0B7
`define IPR_PRL_IDX    10'h0B8
`define IPR_STAT_IDX   10'h0C0
`define IPR_MASK_IDX   10'h0C1
`define IPR_STATE_IDX  10'h0C2

// Reset values
`define IPR_EN_RST     8'h00
`define IPR_PRL_RST    8'h00
`define IPR_PRH_RST    8'h00
`define IPR_EV_RST     3'h0

// Field positions
`define IPR_GATE_BIT   7
`define IPR_EV_TAKE    0
`define IPR_EV_PREEMPT 1
`define IPR_EV_HOLD    2

// Source bit positions inside enable and priority registers
`define IPR_SRC_EXT0   3'h0
`define IPR_SRC_T0     3'h1
`define IPR_SRC_EXT1   3'h2
`define IPR_SRC_T1     3'h3
`define IPR_SRC_SER    3'h4
`define IPR_SRC_T2     3'h5
`define IPR_SRC_CA     3'h6

// Vector addresses
`define IPR_VEC_EXT0   8'h03
`define IPR_VEC_T0     8'h0B
`define IPR_VEC_EXT1   8'h13
`define IPR_VEC_T1     8'h1B
`define IPR_VEC_SER    8'h23
`define IPR_VEC_T2     8'h2B
`define IPR_VEC_CA     8'h33

// Bus answers
`define IPR_RESP_OKAY  2'h0
`define IPR_RESP_SLV   2'h2

`endif

// file: design/ipr_pkg.sv
// Types shared by the prioritizer modules
package ipr_pkg;
    typedef logic [1:0] ipr_lvl_t;

    typedef struct packed {
        logic       valid;
        ipr_lvl_t   level;
        logic [2:0] src;
    } ipr_grant_t;

    typedef struct packed {
        logic [3:0] mask;
        logic       any;
        ipr_lvl_t   top;
    } ipr_ins_t;
endpackage

// file: design/ipr_arbiter.sv
// Level and polling-order winner selection over seven sources
`timescale 1ns/10ps
`include "ipr_map.svh"
module ipr_arbiter (
    input  wire logic [6:0]     active,
    input  wire logic [6:0]     lo_bits,
    input  wire logic [6:0]     hi_bits,
    output ipr_pkg::ipr_grant_t win
);
    ipr_pkg::ipr_lvl_t lvl [7];

    // Polling slot to source bit
    function automatic logic [2:0] poll_bit(input logic [2:0] slot);
        case (slot)
            3'h4:    poll_bit = `IPR_SRC_CA;
            3'h5:    poll_bit = `IPR_SRC_SER;
            3'h6:    poll_bit = `IPR_SRC_T2;
            default: poll_bit = slot;
        endcase
    endfunction

    // Level of each source from its two priority bits
    genvar g;
    generate
        for (g = 0; g < 7; g++)
        begin : g_lvl
            assign lvl[g] = {hi_bits[g], lo_bits[g]}; // R2
        end
    endgenerate

    // Highest level wins, earliest poll slot breaks ties
    always_comb
    begin
        logic [2:0] b;
        b   = 3'h0;
        win = '0;
        for (int s = 6; s >= 0; s--)
        begin
            b = poll_bit(3'(s));
            if (active[b] && (!win.valid || lvl[b] >= win.level)) // R6
            begin
                win.valid = 1'b1;
                win.level = lvl[b];
                win.src   = b;
            end
        end
    end
endmodule

// file: design/ipr_in_service.sv
// Nesting record of handler levels currently in service
`timescale 1ns/10ps
module ipr_in_service (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              push,
    input  wire ipr_pkg::ipr_lvl_t push_level,
    input  wire logic              pop,
    output ipr_pkg::ipr_ins_t      st
);
    logic [3:0] ins;
    logic [3:0] next_ins;

    // Highest level present in a mask
    function automatic ipr_pkg::ipr_lvl_t top_of(input logic [3:0] m);
        top_of = m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
    endfunction

    // Return drops the running level, a new grant adds its level
    always_comb
    begin
        next_ins = ins;
        if (pop && |ins)
            next_ins[top_of(ins)] = 1'b0; // R5
        if (push)
            next_ins[push_level] = 1'b1;
    end

    // Record update
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ins <= 4'h0;
        else
            ins <= next_ins;
    end

    assign st.mask = ins;
    assign st.any  = |ins;
    assign st.top  = top_of(ins);
endmodule

// file: sim/ipr_cpu_model.sv
// Partner model: peripheral request flags and CPU vector acceptance
`timescale 1ns/10ps
module ipr_cpu_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       irq_req,
    input  wire logic [6:0] flag_clear,
    input  wire logic [6:0] set_req,
    input  wire logic [6:0] sw_clr,
    input  wire logic [1:0] ack_dly,
    output logic [6:0]      src_req,
    output logic            vector_ack
);
    logic [1:0] wait_cnt;

    // Flags set by events, cleared by hardware pulse or by software
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            src_req <= 7'h00;
        else
            src_req <= (src_req & ~flag_clear & ~sw_clr) | set_req;
    end

    // CPU takes an offered vector promptly or after a wait
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wait_cnt   <= 2'h0;
            vector_ack <= 1'b0;
        end
        else
        begin
            vector_ack <= irq_req && !vector_ack && wait_cnt >= ack_dly;
            wait_cnt   <= (irq_req && !vector_ack) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the prioritizer: registers, vectors, nesting
`timescale 1ns/10ps
`include "ipr_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    localparam logic [11:0] A_EN = {`IPR_EN_IDX, 2'b00};
    localparam logic [11:0] A_PRH = {`IPR_PRH_IDX, 2'b00};
    localparam logic [11:0] A_PRL = {`IPR_PRL_IDX, 2'b00};
    localparam logic [11:0] A_ST = {`IPR_STAT_IDX, 2'b00};
    localparam logic [11:0] A_MK = {`IPR_MASK_IDX, 2'b00};
    localparam logic [11:0] A_SE = {`IPR_STATE_IDX, 2'b00};
    localparam logic [1:0]  OK = `IPR_RESP_OKAY;
    localparam logic [1:0]  SLV = `IPR_RESP_SLV;
    logic        clk, resetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r, ext_edge_mode, ack_dly;
    logic [6:0]  src_req, flag_clear, set_req, sw_clr;
    logic        vector_ack, handler_return, irq_req, irq;
    logic [7:0]  irq_vector;
    logic [7:0]  takes[$];
    int          bad_count, num_checks, cyc, i;
    logic [7:0]  vecs[7] = '{`IPR_VEC_EXT0, `IPR_VEC_T0, `IPR_VEC_EXT1,
        `IPR_VEC_T1, `IPR_VEC_CA, `IPR_VEC_SER, `IPR_VEC_T2};
    int          srcs[7] = '{0, 1, 2, 3, 6, 4, 5};

    ipr_top uut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_req(src_req),
        .ext_edge_mode(ext_edge_mode), .vector_ack(vector_ack),
        .handler_return(handler_return), .irq_req(irq_req),
        .irq_vector(irq_vector), .flag_clear(flag_clear), .irq(irq));

    ipr_cpu_model cpu (.clk(clk), .resetn(resetn), .irq_req(irq_req),
        .flag_clear(flag_clear), .set_req(set_req), .sw_clr(sw_clr),
        .ack_dly(ack_dly), .src_req(src_req), .vector_ack(vector_ack));

    // Clock generation
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Record every vector the CPU actually takes
    always @(posedge clk)
    begin
        if (resetn === 1'b1 && vector_ack === 1'b1 && irq_req === 1'b1)
            takes.push_back(irq_vector);
    end

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One write, response checked
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, er)
        @(posedge clk); // Gap so bready is not driven twice in one step
    endtask

    // One read into d and r
    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        @(posedge clk); // Gap so rready is not driven twice in one step
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        `CHK(r, OK)
        `CHK(d, e)
    endtask

    // Pulse source events, software clears or a handler return
    task automatic pulse(input logic [6:0] s, input logic [6:0] c,
                         input logic h);
        set_req <= s;
        sw_clr <= c;
        handler_return <= h;
        @(posedge clk);
        set_req <= 7'h00;
        sw_clr <= 7'h00;
        handler_return <= 1'b0;
        @(posedge clk); // Gap before the next pulse drives them again
    endtask

    task automatic expect_take(input logic [7:0] v);
        logic [7:0] got;
        got = 8'h00;
        for (int n = 0; n < 40 && takes.size() == 0; n++)
            @(posedge clk);
        if (takes.size() == 0)
            `CHK(8'h00, v)
        else
        begin
            got = takes.pop_front();
            `CHK(got, v)
        end
    endtask

    task automatic no_take(input int n);
        repeat (n) @(posedge clk);
        `CHK(takes.size(), 0)
    endtask

    // Main sequence
    initial
    begin
        resetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = {12'h000, 12'h000, 32'h0, 4'hF};
        {set_req, sw_clr, handler_return} = {7'h00, 7'h00, 1'b0};
        ext_edge_mode = 2'h0;
        ack_dly = 2'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd_chk(A_EN, 32'h0);
        rd_chk(A_PRL, 32'h0);
        rd_chk(A_PRH, 32'h0);
        rd_chk(A_ST, 32'h0);
        rd_chk(A_MK, 32'h0);
        rd(12'hFFC);
        `CHK(r, SLV)
        wr(A_SE, 32'h0, SLV);
        wr(A_PRL, 32'hFF, OK);
        rd_chk(A_PRL, 32'h7F);
        wr(A_PRL, 32'h0, OK);
        // Gating by global and per-source enables
        pulse(7'h02, 7'h00, 1'b0);
        wr(A_EN, 32'h80, OK);
        no_take(8);
        wr(A_EN, 32'h02, OK);
        no_take(8);
        wr(A_EN, 32'h82, OK);
        expect_take(`IPR_VEC_T0);
        repeat (3) @(posedge clk);
        `CHK(src_req[1], 1'b0)
        pulse(7'h00, 7'h00, 1'b1);
        // Interrupt status, mask and clear
        wr(A_MK, 32'h0, OK);
        `CHK(irq, 1'b0)
        wr(A_MK, 32'h1, OK);
        @(posedge clk);
        `CHK(irq, 1'b1)
        wr(A_ST, 32'h7, OK);
        @(posedge clk);
        `CHK(irq, 1'b0)
        // Seven requests at one level, served in polling order
        ext_edge_mode <= 2'b01;
        ack_dly <= 2'h2;
        wr(A_EN, 32'hFF, OK);
        pulse(7'h7F, 7'h00, 1'b0);
        for (i = 0; i < 7; i++)
        begin
            expect_take(vecs[i]);
            repeat (3) @(posedge clk);
            `CHK(src_req[srcs[i]], !(srcs[i] inside {0, 1, 3}))
            no_take(3);
            pulse(7'h00, 7'h01 << srcs[i], 1'b0);
            pulse(7'h00, 7'h00, 1'b1);
        end
        rd_chk(A_ST, 32'h5);
        wr(A_ST, 32'h7, OK);
        // Nesting across all four levels
        ext_edge_mode <= 2'b10;
        ack_dly <= 2'h0;
        wr(A_PRL, 32'h24, OK);
        wr(A_PRH, 32'h28, OK);
        pulse(7'h04, 7'h00, 1'b0);
        expect_take(`IPR_VEC_EXT1);
        repeat (3) @(posedge clk);
        `CHK(src_req[2], 1'b0)
        pulse(7'h02, 7'h00, 1'b0);
        no_take(5);
        pulse(7'h20, 7'h00, 1'b0);
        expect_take(`IPR_VEC_T2);
        pulse(7'h08, 7'h00, 1'b0);
        no_take(5);
        rd(A_SE);
        `CHK(d[3:0], 4'hA)
        pulse(7'h00, 7'h20, 1'b0);
        pulse(7'h00, 7'h00, 1'b1);
        expect_take(`IPR_VEC_T1);
        rd(A_SE);
        `CHK(d[3:0], 4'h6)
        pulse(7'h00, 7'h00, 1'b1);
        no_take(5);
        pulse(7'h00, 7'h04, 1'b0);
        pulse(7'h00, 7'h00, 1'b1);
        expect_take(`IPR_VEC_T0);
        pulse(7'h00, 7'h00, 1'b1);
        rd(A_ST);
        `CHK(d[1], 1'b1)
        tally_and_finish();
    end
endmodule
